// file: rtl/pac_top.sv
// Process alarm comparator with AXI4-Lite register slave
`timescale 1ns/1ps
module pac_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] rate_alarm_in,
  output logic [3:0] alarm_out,
  output logic [15:0] output_level
);
  localparam int N = pac_pkg::NUM_ALARMS;
  localparam int W = pac_pkg::VAL_W;

  logic control_action_direction;
  logic [3:0] alarm_assign;
  logic [3:0] alarm_one_type_select, alarm_two_type_select;
  logic [3:0] alarm_three_type_select, alarm_four_type_select;
  logic [3:0] type_sel [N];
  logic signed [W-1:0] measured_value, target_value, prev_measured;
  logic signed [W-1:0] thr [N];
  logic signed [W-1:0] low_dev [N];
  logic [3:0] standby_armed;
  logic [3:0] next_alarm;
  logic [3:0] raw_hit;
  logic [3:0] rate_meta, rate_sync;
  logic meas_valid;

  assign type_sel[0] = alarm_one_type_select;
  assign type_sel[1] = alarm_two_type_select;
  assign type_sel[2] = alarm_three_type_select;
  assign type_sel[3] = alarm_four_type_select;

  // Write channel: take address and data in either order
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Write decode helpers
  logic wr_ctrl, wr_assign, wr_types, wr_meas, wr_target, wr_known;
  assign wr_ctrl = do_write && aw_addr == pac_pkg::OFF_CTRL;
  assign wr_assign = do_write && aw_addr == pac_pkg::OFF_ASSIGN;
  assign wr_types = do_write && aw_addr == pac_pkg::OFF_TYPES;
  assign wr_meas = do_write && aw_addr == pac_pkg::OFF_MEAS;
  assign wr_target = do_write && aw_addr == pac_pkg::OFF_TARGET;
  assign wr_known = wr_ctrl || wr_assign || wr_types || wr_meas || wr_target
    || (aw_addr[7:4] == pac_pkg::OFF_THR_BASE[7:4] && aw_addr[1:0] == 2'h0)
    || (aw_addr[7:4] == pac_pkg::OFF_LOW_BASE[7:4] && aw_addr[1:0] == 2'h0);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pac_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? pac_pkg::RESP_OKAY : pac_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Direction and assignment settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_action_direction <= pac_pkg::CTRL_DIR_RESET;
      alarm_assign <= pac_pkg::ASSIGN_RESET;
    end else begin
      if (wr_ctrl && w_strb[0])
        control_action_direction <= w_data[pac_pkg::CTRL_DIR_BIT];
      if (wr_assign && w_strb[0])
        alarm_assign <= w_data[3:0];
    end
  end

  // Type settings; writes land only for assigned alarms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_one_type_select <= pac_pkg::TYPE_RESET;
      alarm_two_type_select <= pac_pkg::TYPE_RESET;
      alarm_three_type_select <= pac_pkg::TYPE_RESET;
      alarm_four_type_select <= pac_pkg::TYPE_RESET;
    end else if (wr_types) begin
      if (alarm_assign[0] && w_strb[0])
        alarm_one_type_select <= w_data[3:0];
      if (alarm_assign[1] && w_strb[0] && w_data[7:4] != pac_pkg::T_LOOP_BREAK)
        alarm_two_type_select <= w_data[7:4];
      if (alarm_assign[2] && w_strb[1] && w_data[11:8] != pac_pkg::T_LOOP_BREAK)
        alarm_three_type_select <= w_data[11:8];
      if (alarm_assign[3] && w_strb[1] && w_data[15:12] != pac_pkg::T_LOOP_BREAK)
        alarm_four_type_select <= w_data[15:12];
    end
  end

  // Measured and target values, per-alarm thresholds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      measured_value <= '0;
      target_value <= '0;
      prev_measured <= '0;
      meas_valid <= 1'b0;
      for (int i = 0; i < N; i++) begin
        thr[i] <= '0;
        low_dev[i] <= '0;
      end
    end else begin
      meas_valid <= wr_meas;
      if (wr_meas) begin
        prev_measured <= measured_value;
        measured_value <= w_data[W-1:0];
      end
      if (wr_target)
        target_value <= w_data[W-1:0];
      for (int i = 0; i < N; i++) begin
        if (do_write && aw_addr == pac_pkg::OFF_THR_BASE + 8'(4 * i))
          thr[i] <= w_data[W-1:0];
        if (do_write && aw_addr == pac_pkg::OFF_LOW_BASE + 8'(4 * i))
          low_dev[i] <= w_data[W-1:0];
      end
    end
  end

  // Output level follows measured value in the chosen direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_level <= 16'h0000;
    end else if (meas_valid && measured_value != prev_measured) begin
      if ((measured_value > prev_measured) == control_action_direction)
        output_level <= output_level + pac_pkg::OUT_STEP;
      else
        output_level <= output_level - pac_pkg::OUT_STEP;
    end
  end

  // Rate-alarm inputs from outside logic, synchronised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_meta <= 4'h0;
      rate_sync <= 4'h0;
    end else begin
      rate_meta <= rate_alarm_in;
      rate_sync <= rate_meta;
    end
  end

  // Alarm region evaluation by type code
  always_comb begin
    logic signed [W:0] pv, sp, hi, lo, x;
    pv = '0;
    sp = '0;
    hi = '0;
    lo = '0;
    x = '0;
    for (int i = 0; i < N; i++) begin
      pv = (W+1)'(measured_value);
      sp = (W+1)'(target_value);
      x = (W+1)'(thr[i]);
      hi = sp + x;
      lo = sp - (W+1)'(low_dev[i]);
      case (type_sel[i])
        pac_pkg::T_BAND_OUT, pac_pkg::T_BAND_OUT_SB:
          raw_hit[i] = pv > hi || pv < lo;
        pac_pkg::T_DEV_HI, pac_pkg::T_DEV_HI_SB:
          raw_hit[i] = pv >= hi;
        pac_pkg::T_DEV_LO, pac_pkg::T_DEV_LO_SB:
          raw_hit[i] = pv <= sp - x;
        pac_pkg::T_BAND_IN:
          raw_hit[i] = pv <= hi && pv >= lo;
        pac_pkg::T_ABS_HI, pac_pkg::T_ABS_HI_SB:
          raw_hit[i] = pv > x;
        pac_pkg::T_ABS_LO, pac_pkg::T_ABS_LO_SB:
          raw_hit[i] = pv < x;
        pac_pkg::T_RATE:
          raw_hit[i] = rate_sync[i];
        pac_pkg::T_TGT_HI:
          raw_hit[i] = sp > x;
        pac_pkg::T_TGT_LO:
          raw_hit[i] = sp < x;
        default:
          raw_hit[i] = 1'b0;
      endcase
    end
  end

  // Types carrying a standby sequence
  function automatic logic has_standby(input logic [3:0] t);
    has_standby = t == pac_pkg::T_BAND_OUT_SB || t == pac_pkg::T_DEV_HI_SB
      || t == pac_pkg::T_DEV_LO_SB || t == pac_pkg::T_ABS_HI_SB
      || t == pac_pkg::T_ABS_LO_SB;
  endfunction : has_standby

  // Standby: armed once outside the alarm region
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_armed <= 4'h0;
    end else begin
      for (int i = 0; i < N; i++)
        if (!raw_hit[i])
          standby_armed[i] <= 1'b1;
    end
  end

  // Final alarm flags, gated by assignment and type
  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_alarm[i] = alarm_assign[i] && raw_hit[i]
        && type_sel[i] != pac_pkg::T_OFF
        && (!has_standby(type_sel[i]) || standby_armed[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      alarm_out <= 4'h0;
    else
      alarm_out <= next_alarm;
  end

  // Read channel: one-cycle registered answer
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pac_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= pac_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pac_pkg::OFF_CTRL: s_axi_rdata <= {31'h0, control_action_direction};
        pac_pkg::OFF_ASSIGN: s_axi_rdata <= {28'h0, alarm_assign};
        pac_pkg::OFF_TYPES: s_axi_rdata <= {16'h0, alarm_four_type_select,
          alarm_three_type_select, alarm_two_type_select, alarm_one_type_select};
        pac_pkg::OFF_MEAS: s_axi_rdata <= {16'h0, measured_value};
        pac_pkg::OFF_TARGET: s_axi_rdata <= {16'h0, target_value};
        pac_pkg::OFF_STATUS: s_axi_rdata <= {24'h0, standby_armed, alarm_out};
        pac_pkg::OFF_OUTLVL: s_axi_rdata <= {16'h0, output_level};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= pac_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  a_dir_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> !control_action_direction)
    else $error("direction not reverse after reset");
  a_type_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> alarm_two_type_select == pac_pkg::TYPE_RESET)
    else $error("type not 2 after reset");
  a_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    type_sel[0] == pac_pkg::T_OFF |=> !alarm_out[0])
    else $error("alarm with type zero");
  a_unassigned_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !alarm_assign[1] |=> !alarm_out[1])
    else $error("unassigned alarm asserted");
  a_no_loopbreak: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_two_type_select != pac_pkg::T_LOOP_BREAK)
    else $error("alarm two took loop-break code");
  a_dev_hi_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_assign[0] && type_sel[0] == pac_pkg::T_DEV_HI
    && (W+1)'(measured_value) >= (W+1)'(target_value) + (W+1)'(thr[0]) |=> alarm_out[0])
    else $error("upper deviation missed");
  a_dev_lo_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_assign[0] && type_sel[0] == pac_pkg::T_DEV_LO
    && (W+1)'(measured_value) <= (W+1)'(target_value) - (W+1)'(thr[0]) |=> alarm_out[0])
    else $error("lower deviation missed");
  a_abs_hi_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_assign[0] && type_sel[0] == pac_pkg::T_ABS_HI
    && measured_value > thr[0] |=> alarm_out[0])
    else $error("absolute upper missed");
  a_abs_lo_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_assign[0] && type_sel[0] == pac_pkg::T_ABS_LO
    && measured_value < thr[0] |=> alarm_out[0])
    else $error("absolute lower missed");
  a_level_direct: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_valid && measured_value > prev_measured && control_action_direction
    |=> output_level == $past(output_level) + pac_pkg::OUT_STEP)
    else $error("direct action level did not rise");
  a_standby_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !standby_armed[0] && has_standby(type_sel[0]) |=> !alarm_out[0])
    else $error("standby alarm too early");
endmodule : pac_top

// file: rtl/pac_pkg.sv
// Package for the process alarm comparator: register map, codes, resets
package pac_pkg;
  localparam int VAL_W = 16;
  localparam int NUM_ALARMS = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ASSIGN = 8'h04;
  localparam logic [7:0] OFF_TYPES = 8'h08;
  localparam logic [7:0] OFF_MEAS = 8'h0C;
  localparam logic [7:0] OFF_TARGET = 8'h10;
  localparam logic [7:0] OFF_THR_BASE = 8'h20;
  localparam logic [7:0] OFF_LOW_BASE = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h40;
  localparam logic [7:0] OFF_OUTLVL = 8'h44;
  // Field layout
  localparam int TYPE_W = 4;
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_RATE_BIT = 4;
  // Reset values and output level step
  localparam logic CTRL_DIR_RESET = 1'b0;
  localparam logic [3:0] TYPE_RESET = 4'h2;
  localparam logic [3:0] ASSIGN_RESET = 4'h0;
  localparam logic [15:0] OUT_STEP = 16'h0001;
  // Alarm type codes
  localparam logic [3:0] T_OFF = 4'h0;
  localparam logic [3:0] T_BAND_OUT = 4'h1;
  localparam logic [3:0] T_DEV_HI = 4'h2;
  localparam logic [3:0] T_DEV_LO = 4'h3;
  localparam logic [3:0] T_BAND_IN = 4'h4;
  localparam logic [3:0] T_BAND_OUT_SB = 4'h5;
  localparam logic [3:0] T_DEV_HI_SB = 4'h6;
  localparam logic [3:0] T_DEV_LO_SB = 4'h7;
  localparam logic [3:0] T_ABS_HI = 4'h8;
  localparam logic [3:0] T_ABS_LO = 4'h9;
  localparam logic [3:0] T_ABS_HI_SB = 4'hA;
  localparam logic [3:0] T_ABS_LO_SB = 4'hB;
  localparam logic [3:0] T_LOOP_BREAK = 4'hC;
  localparam logic [3:0] T_RATE = 4'hD;
  localparam logic [3:0] T_TGT_HI = 4'hE;
  localparam logic [3:0] T_TGT_LO = 4'hF;
  // Write response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pac_pkg

// file: tb/pac_plant.sv
// Model of the sensor side: rate alarm source and alarm relays
`timescale 1ns/1ps
module pac_plant (
  input wire logic aclk,
  input wire logic [3:0] rate_req,
  input wire logic [3:0] alarm_out,
  output logic [3:0] rate_alarm_in,
  output logic [3:0] relay
);
  // Rate detector result, launched just after the edge
  always_ff @(posedge aclk) begin
    rate_alarm_in <= rate_req;
  end
  // Relays follow the alarm flags
  always_ff @(posedge aclk) begin
    relay <= alarm_out;
  end
endmodule : pac_plant

// file: tb/pac_top_tb.sv
// Self-checking bench for the process alarm comparator
`timescale 1ns/1ps
module pac_top_tb;
  typedef struct packed {
    logic [3:0] t;
    logic [15:0] m, g, h, l;
    logic r, e;
  } pac_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [3:0] rate_req = 4'h0, rate_in, alarm_out, relay;
  logic [15:0] output_level, lvl;
  int fails = 0, n_checks = 0;
  pac_row_s rows [24] = '{
    '{4'h0, 16'h0064, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'h1, 16'h0064, 16'h0032, 16'h0014, 16'h0014, 1'h0, 1'h1},
    '{4'h1, 16'h0032, 16'h0032, 16'h0014, 16'h0014, 1'h0, 1'h0},
    '{4'h2, 16'h003C, 16'h0032, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'h2, 16'h003B, 16'h0032, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'h3, 16'h0028, 16'h0032, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'h3, 16'h0029, 16'h0032, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'h4, 16'h0032, 16'h0032, 16'h0014, 16'h0014, 1'h0, 1'h1},
    '{4'h4, 16'h0064, 16'h0032, 16'h0014, 16'h0014, 1'h0, 1'h0},
    '{4'h5, 16'h0064, 16'h0032, 16'h0014, 16'h0014, 1'h0, 1'h1},
    '{4'h6, 16'h003C, 16'h0032, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'h7, 16'h0028, 16'h0032, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'h8, 16'h000B, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'h8, 16'h000A, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'h9, 16'h0009, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'h9, 16'h000A, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'hA, 16'h000B, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'hB, 16'h0009, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'hC, 16'h0064, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'hD, 16'h0000, 16'h0000, 16'h000A, 16'h0000, 1'h1, 1'h1},
    '{4'hD, 16'h0000, 16'h0000, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'hE, 16'h0000, 16'h000B, 16'h000A, 16'h0000, 1'h0, 1'h1},
    '{4'hE, 16'h0000, 16'h000A, 16'h000A, 16'h0000, 1'h0, 1'h0},
    '{4'hF, 16'h0000, 16'h0009, 16'h000A, 16'h0000, 1'h0, 1'h1}
  };
  // Clock of 100 ns period
  always #50 aclk = ~aclk;
  pac_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rate_alarm_in(rate_in), .alarm_out(alarm_out), .output_level(output_level)
  );
  pac_plant i_plant (
    .aclk(aclk), .rate_req(rate_req), .alarm_out(alarm_out),
    .rate_alarm_in(rate_in), .relay(relay)
  );
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Register write over the bus, waits for the response; bready stays up between calls
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        r = bresp;
      end
    end
  endtask : wr
  // Register read over the bus
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
      end
    end
  endtask : rd
  // Verdict and end of run
  task automatic summarize();
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pac_pkg::OFF_CTRL);
    chk("direction", {31'h0, d[0]}, 32'h0);
    rd(pac_pkg::OFF_TYPES);
    chk("types_reset", d, 32'h00002222);
    chk("alarms_unassigned", {28'h0, alarm_out}, 32'h0);
    wr(pac_pkg::OFF_TYPES, 32'h0);
    rd(pac_pkg::OFF_TYPES);
    chk("types_unassigned", d, 32'h00002222);
    wr(pac_pkg::OFF_ASSIGN, 32'h0000000F);
    chk("bresp_okay", {30'h0, r}, {30'h0, pac_pkg::RESP_OKAY});
    wr(pac_pkg::OFF_TYPES, 32'h0000CCC6);
    rd(pac_pkg::OFF_TYPES);
    chk("types_loop_break", d, 32'h00002226);
    repeat (2) @(posedge aclk);
    chk("standby_hold", {28'h0, alarm_out}, 32'h0000000E);
    rd(pac_pkg::OFF_STATUS);
    chk("status", d, 32'h0000000E);
    lvl = output_level;
    wr(pac_pkg::OFF_THR_BASE, 32'h0000000A);
    wr(pac_pkg::OFF_MEAS, 32'h00000014);
    repeat (2) @(posedge aclk);
    chk("standby_armed", {28'h0, alarm_out}, 32'h0000000F);
    chk("level_reverse", {16'h0, output_level}, {16'h0, lvl - 16'h0001});
    wr(pac_pkg::OFF_CTRL, 32'h00000001);
    lvl = output_level;
    wr(pac_pkg::OFF_MEAS, 32'h00000019);
    repeat (2) @(posedge aclk);
    chk("level_direct", {16'h0, output_level}, {16'h0, lvl + 16'h0001});
    rd(8'h80);
    chk("unmapped", {r, d[29:0]}, {2'h2, 30'h0});
    wr(pac_pkg::OFF_STATUS, 32'h0);
    chk("bresp_read_only", {30'h0, r}, {30'h0, pac_pkg::RESP_SLVERR});
    foreach (rows[i]) begin
      wr(pac_pkg::OFF_MEAS, {16'h0, rows[i].m});
      wr(pac_pkg::OFF_TARGET, {16'h0, rows[i].g});
      wr(pac_pkg::OFF_THR_BASE, {16'h0, rows[i].h});
      wr(pac_pkg::OFF_LOW_BASE, {16'h0, rows[i].l});
      rate_req <= {3'h0, rows[i].r};
      wr(pac_pkg::OFF_TYPES, {20'h00002, 8'h22, rows[i].t});
      repeat (6) @(posedge aclk);
      chk("alarm_one", {31'h0, alarm_out[0]}, {31'h0, rows[i].e});
      chk("relay_one", {31'h0, relay[0]}, {31'h0, rows[i].e});
    end
    wr(pac_pkg::OFF_TYPES, 32'h0000CCCC);
    rd(pac_pkg::OFF_TYPES);
    chk("type_one_loop_break", d, 32'h0000222C);
    summarize();
  end
endmodule : pac_top_tb
